/* File: core/ccdf_params.svh */
// Purpose: Constants of the CCD front-end control block.
// Assumes: Included by bare name from the package and modules.
// Notes:   Offsets, field positions, reset values and counts only.
`ifndef CCDF_PARAMS_SVH
`define CCDF_PARAMS_SVH
// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define CCDF_FRAME_BITS    16
`define CCDF_TEST_BIT      15
`define CCDF_ADDR_MSB      14
`define CCDF_ADDR_LSB      12
`define CCDF_DATA_MSB      11
// ----------------------------------------------------------------
// Field addresses
// ----------------------------------------------------------------
`define CCDF_ADDR_MODE     3'h0
`define CCDF_ADDR_GAIN     3'h1
`define CCDF_ADDR_CLAMP    3'h2
`define CCDF_ADDR_POL      3'h3
`define CCDF_ADDR_DELAY    3'h4
`define CCDF_ADDR_LAST     3'h4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCDF_RST_MODE      1'h0
`define CCDF_RST_GAIN      10'h200
`define CCDF_RST_CLAMP     4'h8
`define CCDF_RST_POL       3'h0
`define CCDF_RST_DELAY     2'h0
// ----------------------------------------------------------------
// Polarity bit positions and timing
// ----------------------------------------------------------------
`define CCDF_POL_DUMMY     0
`define CCDF_POL_BLACK     1
`define CCDF_POL_SAMPLE    2
`define CCDF_DELAY_NS_0    4'h0
`define CCDF_DELAY_NS_1    4'h5
`define CCDF_DELAY_NS_2    4'hA
`define CCDF_DELAY_NS_3    4'hD
`define CCDF_APPLY_EDGES   5
`endif

/* File: core/ccdf_pkg.sv */
// Purpose: Types shared by the CCD front-end control modules.
// Assumes: Constants come from the params header.
// Notes:   Types only.
`include "ccdf_params.svh"
package ccdf_pkg;
  typedef logic [2:0]  ccdf_addr_t;
  typedef logic [15:0] ccdf_frame_t;
  typedef logic [9:0]  ccdf_pix_t;
  // Update sequencer, Gray along idle -> wait
  typedef enum logic [1:0] {
    CCDF_UPD_IDLE = 2'b00,
    CCDF_UPD_WAIT = 2'b01
  } ccdf_upd_t;
endpackage : ccdf_pkg

/* File: core/ccdf_ser_if.sv */
// Purpose: Carries latched serial frames from receiver to control.
// Assumes: One clock domain.
// Notes:   valid is a one-cycle pulse with word stable beside it.
`timescale 1ns/100ps
interface ccdf_ser_if;
  logic [15:0] word;
  logic        valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface : ccdf_ser_if

/* File: core/ccdf_serial_rx.sv */
// Purpose: Serial shift register and parallel latch of frames.
// Assumes: Serial pins synchronous to core_clk_i, edges slower than it.
// Notes:   Only a complete frame of exactly frame length is passed on.
`timescale 1ns/100ps
`include "ccdf_params.svh"
module ccdf_serial_rx #(
  parameter int FRAME_BITS = `CCDF_FRAME_BITS
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Serial pins
  input  wire logic ser_clk_i,
  input  wire logic serial_data_in_i,
  input  wire logic serial_load_strobe_i,
  // Frame out
  ccdf_ser_if.src   ser
);
  import ccdf_pkg::*;

  if (FRAME_BITS != 16) begin : g_chk
    $error("ccdf_serial_rx: frame length must be 16");
  end

  logic        sclk_prev_reg, sclk_prev_next;
  logic        load_prev_reg, load_prev_next;
  logic [15:0] shift_reg,     shift_next;
  logic [4:0]  cnt_reg,       cnt_next;
  logic [15:0] word_reg,      word_next;
  logic        valid_reg,     valid_next;
  logic        sclk_rise;
  logic        load_rise;

  // ----------------------------------------------------------------
  // Shift and latch
  // ----------------------------------------------------------------
  // Counter saturates so an overlong frame never aliases to 16
  always_comb begin
    sclk_rise      = ser_clk_i & ~sclk_prev_reg;
    load_rise      = serial_load_strobe_i & ~load_prev_reg;
    sclk_prev_next = ser_clk_i;
    load_prev_next = serial_load_strobe_i;
    shift_next     = shift_reg;
    cnt_next       = cnt_reg;
    word_next      = word_reg;
    valid_next     = 1'b0;
    if (!serial_load_strobe_i && sclk_rise) begin
      shift_next = {shift_reg[14:0], serial_data_in_i};
      if (cnt_reg != 5'h1F) cnt_next = cnt_reg + 5'h01;
    end
    if (load_rise) begin
      cnt_next = 5'h00;
      if (cnt_reg == 5'(FRAME_BITS)) begin
        word_next  = shift_reg;
        valid_next = 1'b1;
      end
    end else if (serial_load_strobe_i) begin
      cnt_next = 5'h00;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_reg <= 1'b0;
      load_prev_reg <= 1'b1;
      shift_reg     <= 16'h0000;
      cnt_reg       <= 5'h00;
      word_reg      <= 16'h0000;
      valid_reg     <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      load_prev_reg <= load_prev_next;
      shift_reg     <= shift_next;
      cnt_reg       <= cnt_next;
      word_reg      <= word_next;
      valid_reg     <= valid_next;
    end
  end

  assign ser.word  = word_reg;
  assign ser.valid = valid_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_frame_len: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    valid_reg |-> $past(cnt_reg) == 5'h10)
    else $error("frame passed with wrong bit count");
  chk_shift_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(serial_load_strobe_i) |-> $stable(shift_reg))
    else $error("shift while load strobe high");
endmodule : ccdf_serial_rx

/* File: core/ccdf_frontend_ctrl.sv */
// Purpose: Control logic of a CCD front-end converter.
// Assumes: All pins synchronous to core_clk_i; strobes slower than it.
// Notes:   Strobe outputs are normalised to active low, one cycle late.
//
// Overview of operation
// - Delay select maps to 0/5/10/13 ns.
// - Reset loads every field with its default.
// - Reset: stand-by off, delay select 00.
// - Reset: gain code 0x200, 0 dB.
// - Reset: black clamp level code 1000.
// - Reset: all three polarity bits cleared.
// - Sampling runs from external sample strobes.
// - Output data changes only on conversion clock, or clears in stand-by.
// - Active black clamp pulse runs clamp loop.
// - Active dummy clamp pulse runs input clamp.
// - Both sample strobes share one polarity bit; each clamp pulse has its own.
// - Stand-by masks clock and strobes, held high.
// - Frames are 16 bits, MSB first, fixed layout.
// - Shift on serial clock rise, load low.
// - Field updates five conversion clock edges after latch.
// - Mode bit selects stand-by; interface stays live.
`timescale 1ns/100ps
`include "ccdf_params.svh"
module ccdf_frontend_ctrl #(
  parameter int APPLY_EDGES = `CCDF_APPLY_EDGES
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // Serial host pins
  input  wire logic              ser_clk_i,
  input  wire logic              serial_data_in_i,
  input  wire logic              serial_load_strobe_i,
  // Timing generator pins
  input  wire logic              conversion_clock_i,
  input  wire logic              reference_sample_strobe_i,
  input  wire logic              data_sample_strobe_i,
  input  wire logic              black_clamp_pulse_i,
  input  wire logic              dummy_clamp_pulse_i,
  input  wire logic              preblank_input_n_i,
  // Converter core data
  input  wire ccdf_pkg::ccdf_pix_t adc_data_i,
  // Configuration fields
  output logic                   standby_o,
  output logic [9:0]             gain_code_o,
  output logic [3:0]             black_clamp_level_o,
  output logic [2:0]             strobe_polarity_o,
  output logic [1:0]             output_delay_sel_o,
  output logic [3:0]             output_delay_ns_o,
  // Internal clock at pin level and strobes active low, all held high in stand-by
  output logic                   conversion_clock_int_o,
  output logic                   reference_sample_int_n_o,
  output logic                   data_sample_int_n_o,
  output logic                   black_clamp_int_n_o,
  output logic                   dummy_clamp_int_n_o,
  // Clamp controls and data out
  output logic                   black_loop_run_o,
  output logic                   input_clamp_run_o,
  output ccdf_pkg::ccdf_pix_t    data_o
);
  import ccdf_pkg::*;

  if (APPLY_EDGES < 1 || APPLY_EDGES > 15) begin : g_chk
    $error("ccdf_frontend_ctrl: APPLY_EDGES out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Delay select to nominal added delay in ns
  function automatic logic [3:0] ccdf_delay_ns(input logic [1:0] sel);
    case (sel)
      2'h0:    ccdf_delay_ns = `CCDF_DELAY_NS_0;
      2'h1:    ccdf_delay_ns = `CCDF_DELAY_NS_1;
      2'h2:    ccdf_delay_ns = `CCDF_DELAY_NS_2;
      default: ccdf_delay_ns = `CCDF_DELAY_NS_3;
    endcase
  endfunction : ccdf_delay_ns

  // Pin level to active-low form under a polarity bit
  function automatic logic ccdf_norm(input logic pin, input logic pol_high);
    ccdf_norm = pin ^ pol_high;
  endfunction : ccdf_norm

  ccdf_ser_if ser ();

  ccdf_serial_rx #(
    .FRAME_BITS           (`CCDF_FRAME_BITS)
  ) u_rx (
    .core_clk_i           (core_clk_i),
    .nrst_i               (nrst_i),
    .ser_clk_i            (ser_clk_i),
    .serial_data_in_i     (serial_data_in_i),
    .serial_load_strobe_i (serial_load_strobe_i),
    .ser                  (ser)
  );

  // ----------------------------------------------------------------
  // Frame check and update sequencer
  // ----------------------------------------------------------------
  ccdf_upd_t   upd_reg,   upd_next;
  ccdf_addr_t  paddr_reg, paddr_next;
  logic [11:0] pdata_reg, pdata_next;
  logic [3:0]  ecnt_reg,  ecnt_next;
  logic        cclk_prev_reg, cclk_prev_next;
  logic        conv_rise;
  logic        accept;
  logic        apply;
  ccdf_addr_t  f_addr;

  always_comb begin
    f_addr = ser.word[`CCDF_ADDR_MSB:`CCDF_ADDR_LSB];
    conv_rise = conversion_clock_i & ~cclk_prev_reg;
    // Reserved addresses and test frames never reach a field
    accept = ser.valid & ~ser.word[`CCDF_TEST_BIT]
             & (f_addr <= `CCDF_ADDR_LAST);
    cclk_prev_next = conversion_clock_i;
    upd_next   = upd_reg;
    paddr_next = paddr_reg;
    pdata_next = pdata_reg;
    ecnt_next  = ecnt_reg;
    apply      = 1'b0;
    case (upd_reg)
      CCDF_UPD_IDLE: begin
        if (accept) begin
          upd_next   = CCDF_UPD_WAIT;
          paddr_next = f_addr;
          pdata_next = ser.word[`CCDF_DATA_MSB:0];
          ecnt_next  = 4'h0;
        end
      end
      CCDF_UPD_WAIT: begin
        // Raw pin clock: updates go on in stand-by too
        if (conv_rise) begin
          if (ecnt_reg == 4'(APPLY_EDGES - 1)) begin
            apply    = 1'b1;
            upd_next = CCDF_UPD_IDLE;
          end else begin
            ecnt_next = ecnt_reg + 4'h1;
          end
        end
        // A newer frame replaces the pending one and restarts the wait
        if (accept) begin
          upd_next   = CCDF_UPD_WAIT;
          paddr_next = f_addr;
          pdata_next = ser.word[`CCDF_DATA_MSB:0];
          ecnt_next  = 4'h0;
          apply      = 1'b0;
        end
      end
      default: upd_next = CCDF_UPD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upd_reg       <= CCDF_UPD_IDLE;
      paddr_reg     <= 3'h0;
      pdata_reg     <= 12'h000;
      ecnt_reg      <= 4'h0;
      cclk_prev_reg <= 1'b1; // No false rise if the pin is high at release
    end else begin
      upd_reg       <= upd_next;
      paddr_reg     <= paddr_next;
      pdata_reg     <= pdata_next;
      ecnt_reg      <= ecnt_next;
      cclk_prev_reg <= cclk_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic       mode_reg,  mode_next;
  logic [9:0] gain_reg,  gain_next;
  logic [3:0] clamp_reg, clamp_next;
  logic [2:0] pol_reg,   pol_next;
  logic [1:0] dly_reg,   dly_next;
  logic [3:0] dns_reg,   dns_next;

  always_comb begin
    mode_next  = mode_reg;
    gain_next  = gain_reg;
    clamp_next = clamp_reg;
    pol_next   = pol_reg;
    dly_next   = dly_reg;
    if (apply) begin
      case (paddr_reg)
        `CCDF_ADDR_MODE:  mode_next  = pdata_reg[0];
        `CCDF_ADDR_GAIN:  gain_next  = pdata_reg[9:0];
        `CCDF_ADDR_CLAMP: clamp_next = pdata_reg[3:0];
        `CCDF_ADDR_POL:   pol_next   = pdata_reg[2:0];
        `CCDF_ADDR_DELAY: dly_next   = pdata_reg[1:0];
        default:          mode_next  = mode_reg;
      endcase
    end
    dns_next = ccdf_delay_ns(dly_next);
  end

  // Reset pin is the only way back to defaults
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg  <= `CCDF_RST_MODE;
      gain_reg  <= `CCDF_RST_GAIN;
      clamp_reg <= `CCDF_RST_CLAMP;
      pol_reg   <= `CCDF_RST_POL;
      dly_reg   <= `CCDF_RST_DELAY;
      dns_reg   <= `CCDF_DELAY_NS_0;
    end else begin
      mode_reg  <= mode_next;
      gain_reg  <= gain_next;
      clamp_reg <= clamp_next;
      pol_reg   <= pol_next;
      dly_reg   <= dly_next;
      dns_reg   <= dns_next;
    end
  end

  // ----------------------------------------------------------------
  // Strobe conditioning, clamps and data
  // ----------------------------------------------------------------
  logic      cclk_int_reg, cclk_int_next;
  logic      rsmp_reg,     rsmp_next;
  logic      dsmp_reg,     dsmp_next;
  logic      bclp_reg,     bclp_next;
  logic      dclp_reg,     dclp_next;
  logic      bloop_reg,    bloop_next;
  logic      iclp_reg,     iclp_next;
  ccdf_pix_t data_reg,     data_next;

  // Polarity and stand-by act on live pins; one cycle of latency
  always_comb begin
    cclk_int_next = mode_reg ? 1'b1 : conversion_clock_i;
    rsmp_next = mode_reg ? 1'b1
              : ccdf_norm(reference_sample_strobe_i, pol_reg[`CCDF_POL_SAMPLE]);
    dsmp_next = mode_reg ? 1'b1
              : ccdf_norm(data_sample_strobe_i, pol_reg[`CCDF_POL_SAMPLE]);
    bclp_next = mode_reg ? 1'b1
              : ccdf_norm(black_clamp_pulse_i, pol_reg[`CCDF_POL_BLACK]);
    dclp_next = mode_reg ? 1'b1
              : ccdf_norm(dummy_clamp_pulse_i, pol_reg[`CCDF_POL_DUMMY]);
    // Preblank is not gated here; keeping them apart is the host's job
    bloop_next = ~bclp_next;
    iclp_next  = ~dclp_next;
    data_next  = data_reg;
    if (mode_reg) begin
      data_next = 10'h000;
    end else if (conv_rise) begin
      data_next = preblank_input_n_i ? adc_data_i : 10'h000;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cclk_int_reg <= 1'b1;
      rsmp_reg     <= 1'b1;
      dsmp_reg     <= 1'b1;
      bclp_reg     <= 1'b1;
      dclp_reg     <= 1'b1;
      bloop_reg    <= 1'b0;
      iclp_reg     <= 1'b0;
      data_reg     <= 10'h000;
    end else begin
      cclk_int_reg <= cclk_int_next;
      rsmp_reg     <= rsmp_next;
      dsmp_reg     <= dsmp_next;
      bclp_reg     <= bclp_next;
      dclp_reg     <= dclp_next;
      bloop_reg    <= bloop_next;
      iclp_reg     <= iclp_next;
      data_reg     <= data_next;
    end
  end

  // Outputs straight from flops
  assign standby_o                = mode_reg;
  assign gain_code_o              = gain_reg;
  assign black_clamp_level_o      = clamp_reg;
  assign strobe_polarity_o        = pol_reg;
  assign output_delay_sel_o       = dly_reg;
  assign output_delay_ns_o        = dns_reg;
  assign conversion_clock_int_o   = cclk_int_reg;
  assign reference_sample_int_n_o = rsmp_reg;
  assign data_sample_int_n_o      = dsmp_reg;
  assign black_clamp_int_n_o      = bclp_reg;
  assign dummy_clamp_int_n_o      = dclp_reg;
  assign black_loop_run_o         = bloop_reg;
  assign input_clamp_run_o        = iclp_reg;
  assign data_o                   = data_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_delay_map: assert property (
    output_delay_ns_o == (output_delay_sel_o == 2'h0 ? 4'h0 :
                          output_delay_sel_o == 2'h1 ? 4'h5 :
                          output_delay_sel_o == 2'h2 ? 4'hA : 4'hD))
    else $error("delay ns does not match select");
  chk_reset_mode: assert property ($rose(nrst_i) |->
    !standby_o && output_delay_sel_o == 2'h0)
    else $error("mode or delay not default after reset");
  chk_reset_gain: assert property ($rose(nrst_i) |-> gain_code_o == 10'h200)
    else $error("gain not default after reset");
  chk_reset_clamp: assert property ($rose(nrst_i) |->
    black_clamp_level_o == 4'h8 && strobe_polarity_o == 3'h0)
    else $error("clamp level or polarity not default after reset");
  chk_data_edge: assert property ($changed(data_o) |->
    $past(conv_rise) || $past(mode_reg))
    else $error("data changed off conversion edge");
  chk_black_pol: assert property (!mode_reg |=>
    black_clamp_int_n_o == $past(black_clamp_pulse_i ^ pol_reg[1])
    && black_loop_run_o == !black_clamp_int_n_o)
    else $error("black clamp polarity wrong");
  chk_dummy_pol: assert property (!mode_reg |=>
    dummy_clamp_int_n_o == $past(dummy_clamp_pulse_i ^ pol_reg[0])
    && input_clamp_run_o == !dummy_clamp_int_n_o)
    else $error("dummy clamp polarity wrong");
  chk_standby_mask: assert property (mode_reg |=> conversion_clock_int_o
    && reference_sample_int_n_o && data_sample_int_n_o
    && black_clamp_int_n_o && dummy_clamp_int_n_o && data_o == 10'h000)
    else $error("stand-by did not mask strobes");
  chk_reject_bad: assert property (ser.valid && (ser.word[15]
    || ser.word[14:12] > 3'h4) && upd_reg == CCDF_UPD_IDLE |=> upd_reg == CCDF_UPD_IDLE)
    else $error("bad frame started an update");
  chk_apply_edges: assert property (accept |=>
    upd_reg == CCDF_UPD_WAIT && ecnt_reg == 4'h0)
    else $error("accepted frame did not restart the edge count");
  chk_apply_count: assert property ($changed({standby_o, gain_code_o,
    black_clamp_level_o, strobe_polarity_o, output_delay_sel_o}) |-> $past(apply))
    else $error("field changed without a completed update wait");

  cov_gain_write: cover property (apply && paddr_reg == `CCDF_ADDR_GAIN);
  cov_standby:    cover property ($rose(mode_reg));
  cov_reject:     cover property (ser.valid && !accept);
  cov_replace:    cover property (upd_reg == CCDF_UPD_WAIT && accept);
endmodule : ccdf_frontend_ctrl

/* File: tb/ccdf_host_model.sv */
// Purpose: Timing generator and serial host standing at the pins.
// Assumes: Steps on core clock falling edges.
// Notes:   Conversion clock runs free; serial clock idles low.
`timescale 1ns/100ps
module ccdf_host_model (
  // Core clock
  input  wire logic clk_i,
  // Serial and conversion pins
  output logic      ser_clk_o,
  output logic      serial_data_o,
  output logic      load_o,
  output logic      conv_clk_o
);
  logic [1:0] div;
  initial begin
    div           = 2'h0;
    ser_clk_o     = 1'b0;
    serial_data_o = 1'b0;
    load_o        = 1'b1;
    conv_clk_o    = 1'b0;
  end
  // Conversion clock, four core cycles a period
  always @(negedge clk_i) begin
    div        <= div + 2'h1;
    conv_clk_o <= div[1];
  end
  // Whole frame, MSB first, load low throughout
  task automatic send(input logic [15:0] w);
    @(negedge clk_i);
    load_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk_i);
      serial_data_o = w[i];
      ser_clk_o     = 1'b0;
      @(negedge clk_i);
      ser_clk_o = 1'b1;
    end
    @(negedge clk_i);
    ser_clk_o     = 1'b0;
    serial_data_o = ~serial_data_o; // Released line shows no stale bit
    @(negedge clk_i);
    load_o = 1'b1;
  endtask : send
endmodule : ccdf_host_model

/* File: tb/ccdf_frontend_ctrl_test.sv */
// Purpose: Self-checking bench of the front-end control block.
// Assumes: Inputs change on falling edges of core_clk_i.
// Notes:   Table rows hold a frame beside the whole field state after it.
`timescale 1ns/100ps
module ccdf_frontend_ctrl_test;
  import ccdf_pkg::*;
  localparam logic [23:0] DFLT = {1'b0, 10'h200, 4'h8, 3'h0, 2'h0, 4'h0};
  logic       core_clk_i = 1'b0;
  logic       nrst_i     = 1'b0;
  logic       ser_clk, serial_data_in, load, conv;
  logic       ref_s = 1'b1, dat_s = 1'b1, blk = 1'b1, dum = 1'b1, preblank_input_n = 1'b1;
  ccdf_pix_t  adc = 10'h2A5, data;
  logic       stby, conv_int, ref_n, dat_n, blk_n, dum_n, blk_run, in_run;
  logic [9:0] gain;
  logic [3:0] clamp, ns;
  logic [2:0] pol;
  logic [1:0] sel;
  logic [23:0] cfg, exp_cfg;
  int         errors = 0, checked = 0;
  logic [39:0] rows [12] = '{
    {16'h1155, 1'b0, 10'h155, 4'h8, 3'h0, 2'h0, 4'h0},
    {16'h2FF3, 1'b0, 10'h155, 4'h3, 3'h0, 2'h0, 4'h0},
    {16'h3005, 1'b0, 10'h155, 4'h3, 3'h5, 2'h0, 4'h0},
    {16'h4001, 1'b0, 10'h155, 4'h3, 3'h5, 2'h1, 4'h5},
    {16'h4002, 1'b0, 10'h155, 4'h3, 3'h5, 2'h2, 4'hA},
    {16'h4003, 1'b0, 10'h155, 4'h3, 3'h5, 2'h3, 4'hD},
    {16'h8000, 1'b0, 10'h155, 4'h3, 3'h5, 2'h3, 4'hD},
    {16'h5FFF, 1'b0, 10'h155, 4'h3, 3'h5, 2'h3, 4'hD},
    {16'h0001, 1'b1, 10'h155, 4'h3, 3'h5, 2'h3, 4'hD},
    {16'h13FF, 1'b1, 10'h3FF, 4'h3, 3'h5, 2'h3, 4'hD},
    {16'h4000, 1'b1, 10'h3FF, 4'h3, 3'h5, 2'h0, 4'h0},
    {16'h0000, 1'b0, 10'h3FF, 4'h3, 3'h5, 2'h0, 4'h0}};
  assign cfg = {stby, gain, clamp, pol, sel, ns};
  ccdf_host_model host (.clk_i(core_clk_i), .ser_clk_o(ser_clk), .serial_data_o(serial_data_in),
    .load_o(load), .conv_clk_o(conv));
  ccdf_frontend_ctrl #(.APPLY_EDGES(5)) uut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ser_clk_i(ser_clk),
    .serial_data_in_i(serial_data_in), .serial_load_strobe_i(load), .conversion_clock_i(conv),
    .reference_sample_strobe_i(ref_s), .data_sample_strobe_i(dat_s),
    .black_clamp_pulse_i(blk), .dummy_clamp_pulse_i(dum), .preblank_input_n_i(preblank_input_n),
    .adc_data_i(adc), .standby_o(stby), .gain_code_o(gain), .black_clamp_level_o(clamp),
    .strobe_polarity_o(pol), .output_delay_sel_o(sel), .output_delay_ns_o(ns),
    .conversion_clock_int_o(conv_int), .reference_sample_int_n_o(ref_n),
    .data_sample_int_n_o(dat_n), .black_clamp_int_n_o(blk_n), .dummy_clamp_int_n_o(dum_n),
    .black_loop_run_o(blk_run), .input_clamp_run_o(in_run), .data_o(data));
  // 50 MHz core clock
  always #10 core_clk_i = ~core_clk_i;
  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_cfg(input string what, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_cfg
  task automatic chk_out(input string what, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_out
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog, about seventeen times the expected run length
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk_i);
    chk_cfg("reset_cfg", DFLT, cfg);
    nrst_i  = 1'b1;
    exp_cfg = DFLT;
    // Table: field must wait for the conversion clock, then take the row value
    for (int k = 0; k < 12; k++) begin
      host.send(rows[k][39:24]);
      repeat (10) @(negedge core_clk_i);
      chk_cfg("cfg_early", exp_cfg, cfg);
      repeat (40) @(negedge core_clk_i);
      exp_cfg = rows[k][23:0];
      chk_cfg("cfg", exp_cfg, cfg);
    end
    // Polarity 101: dummy and sample strobes active high, black active low
    for (int p = 0; p < 16; p++) begin
      {ref_s, dat_s, blk, dum} = p[3:0];
      repeat (2) @(negedge core_clk_i);
      chk_out("strobes", {6'h0, ~p[3], ~p[2], p[1], ~p[0]}, {6'h0, ref_n, dat_n, blk_n, dum_n});
      chk_out("clamp_run", {8'h0, ~p[1], p[0]}, {8'h0, blk_run, in_run});
    end
    // Data follows converter word; preblank only with black clamp idle
    blk = 1'b1;
    repeat (8) @(negedge core_clk_i);
    chk_out("data", 10'h2A5, data);
    // Internal conversion clock trails the pin by half a core cycle, equal at each falling edge
    for (int c = 0; c < 4; c++) begin
      @(negedge core_clk_i);
      chk_out("conv_int", {9'h0, conv}, {9'h0, conv_int});
    end
    preblank_input_n = 1'b0;
    repeat (8) @(negedge core_clk_i);
    chk_out("data_blank", 10'h000, data);
    preblank_input_n = 1'b1;
    // Stand-by: every internal strobe held high, data low five bits zero
    {ref_s, dat_s, blk, dum} = 4'h0;
    host.send(16'h0001);
    repeat (40) @(negedge core_clk_i);
    for (int c = 0; c < 4; c++) begin
      @(negedge core_clk_i);
      chk_out("masked", 10'h3E0, {conv_int, ref_n, dat_n, blk_n, dum_n, data[4:0]});
    end
    // Reset in mid-run restores every default
    nrst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk_cfg("rerst_cfg", DFLT, cfg);
    nrst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk_cfg("post_rst_cfg", DFLT, cfg);
    wrap_up();
  end
endmodule : ccdf_frontend_ctrl_test
